// ---- rtl/sqb_consts.vh ----
// Constants of the quad-bank synchronous DRAM access interface.
// Assumes inclusion by the design files under rtl/; definitions only.
`ifndef SQB_CONSTS_VH
`define SQB_CONSTS_VH

// Command code {cs_n, ras_n, cas_n, we_n}
`define SQB_CMD_NOP        4'h7
`define SQB_CMD_ACTIVE     4'h3
`define SQB_CMD_READ       4'h5
`define SQB_CMD_WRITE      4'h4
`define SQB_CMD_BST        4'h6
`define SQB_CMD_PRECHARGE  4'h2
`define SQB_CMD_REFRESH    4'h1
`define SQB_CMD_LOAD_MODE  4'h0

// Burst length field encoding
`define SQB_BL_1           3'h0
`define SQB_BL_2           3'h1
`define SQB_BL_4           3'h2
`define SQB_BL_8           3'h3
`define SQB_BL_PAGE        3'h7

// Address field position, row width and bank count
`define SQB_AP_BIT         10
`define SQB_ROW_BITS       13
`define SQB_BANKS          4

// Power state codes
`define SQB_PWR_RUN        3'h0
`define SQB_PWR_PRE_PD     3'h1
`define SQB_PWR_ACT_PD     3'h2
`define SQB_PWR_SUSPEND    3'h3
`define SQB_PWR_SELF_REF   3'h4

// Read data mask latency in clocks
`define SQB_DQM_RD_LAT     2

`endif

// ---- rtl/sqb_bank.v ----
// One bank's row state: open flag, open row and self-timed auto precharge.
// Assumes commands already decoded and qualified by the top module.
`timescale 1ns/1ns
`include "sqb_consts.vh"
module sqb_bank #(
    parameter ROW_W = 13
) (
    input  wire             clk,
    input  wire             sys_rst,
    input  wire             clk_act,
    input  wire             do_activate,
    input  wire             do_precharge,
    input  wire             arm_auto_pre,
    input  wire             burst_done,
    input  wire [ROW_W-1:0] row_in,
    output reg              open_q,
    output reg  [ROW_W-1:0] row_q
);
    reg auto_pre_q;

    // Open and close the row; auto precharge closes it on burst end
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            open_q     <= 1'b0;
            row_q      <= {ROW_W{1'b0}};
            auto_pre_q <= 1'b0;
        end
        else if (clk_act)
        begin
            if (do_activate)
            begin
                open_q <= 1'b1;
                row_q  <= row_in;
            end
            else if (do_precharge)
            begin
                open_q     <= 1'b0;
                auto_pre_q <= 1'b0;
            end
            else if (auto_pre_q && burst_done)
            begin
                open_q     <= 1'b0;
                auto_pre_q <= 1'b0;
            end
            if (arm_auto_pre)
                auto_pre_q <= 1'b1;
        end
    end
endmodule

// ---- rtl/sqb_core.v ----
// Access and clock-enable logic of a quad-bank synchronous DRAM.
// Assumes an external controller on clk; pins pass the same clock domain.
// Operation
// - Sample all inputs on rising clock edge
// - Four banks, 8192 rows, width-dependent columns
// - Active takes bank select and row address
// - Read or write address gives start column
// - Bursts of 1, 2, 4, 8 or page
// - Burst terminate ends any burst early
// - Auto precharge closes row after burst, except burst length 1
// - New column address accepted every clock
// - Precharge one bank while another accessed
// - Each active edge advances counter and output registers
// - Clock enable high means clock active
// - Input buffers disabled during power-down
// - Chip select high masks every command
// - Bursts and data mask survive chip select
// - Command from strobes with chip select
// - Mask blocks writes, tristates reads two later
// - Bit ten: auto precharge or all banks
// - Column bits depend on data width
`timescale 1ns/1ns
`include "sqb_consts.vh"
module sqb_core #(
    parameter DQ_W   = 16,
    parameter COL_W  = 9,
    parameter ADDR_W = 13,
    parameter CAS_LAT = 2
) (
    input  wire              clk,
    input  wire              sys_rst,
    input  wire              clk_en,
    input  wire              cs_n,
    input  wire              ras_n,
    input  wire              cas_n,
    input  wire              we_n,
    input  wire [1:0]        bank_select,
    input  wire [ADDR_W-1:0] mux_address,
    input  wire              data_mask_low_byte,
    input  wire              data_mask_high_byte,
    input  wire [2:0]        burst_length,
    input  wire              burst_interleave,
    input  wire [DQ_W-1:0]   dq_in,
    output reg  [DQ_W-1:0]   dq_out,
    output reg  [DQ_W/8-1:0] dq_oe_n,
    output reg               wr_stb,
    output reg  [1:0]        wr_bank,
    output reg  [ADDR_W-1:0] wr_row,
    output reg  [COL_W-1:0]  wr_col,
    output reg  [DQ_W-1:0]   wr_data,
    output reg  [DQ_W/8-1:0] wr_byte_en,
    output reg  [DQ_W-1:0]   rd_data_last,
    output reg  [2:0]        pwr_state,
    output reg  [3:0]        bank_open,
    output reg               burst_busy,
    input  wire [DQ_W-1:0]   array_rd_data
);
    localparam LANES = DQ_W/8;

    // Burst length decode, called at burst start and held in len_q for run checks
    function [COL_W:0] bl_len;
        input [2:0] code;
        begin
            case (code)
                `SQB_BL_1: bl_len = {{(COL_W-3){1'b0}}, 4'h1};
                `SQB_BL_2: bl_len = {{(COL_W-3){1'b0}}, 4'h2};
                `SQB_BL_4: bl_len = {{(COL_W-3){1'b0}}, 4'h4};
                `SQB_BL_8: bl_len = {{(COL_W-3){1'b0}}, 4'h8};
                default:   bl_len = {1'b1, {COL_W{1'b0}}}; // Full row
            endcase
        end
    endfunction

    // Next column in the burst: wrap inside the block, sequential or interleaved
    function [COL_W-1:0] next_col;
        input [COL_W-1:0] start;
        input [COL_W:0]   idx;
        input [COL_W:0]   len;
        input             ilv;
        reg   [COL_W-1:0] mask;
        reg   [COL_W-1:0] off;
        begin
            mask = len[COL_W-1:0] - 1'b1;
            if (len[COL_W])
                mask = {COL_W{1'b1}};
            off = ilv ? (start ^ idx[COL_W-1:0]) : (start + idx[COL_W-1:0]);
            next_col = (start & ~mask) | (off & mask);
        end
    endfunction

    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};

    // Three-flop synchroniser on clock enable, the pin may move at any time
    reg cke_s1_q, cke_s2_q, cke_s3_q;
    reg sref_q; // Self refresh asked for, held until the power state leaves run
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            sref_q   <= 1'b0;
            cke_s1_q <= 1'b1;
            cke_s2_q <= 1'b1;
            cke_s3_q <= 1'b1;
        end
        else
        begin
            sref_q   <= is_sref | (sref_q & (pwr_state == `SQB_PWR_RUN));
            cke_s1_q <= clk_en;
            cke_s2_q <= cke_s1_q;
            cke_s3_q <= cke_s2_q;
        end
    end
    // Asleep modes only exit once two stages agree high
    wire cke_hi_agree = cke_s2_q & cke_s3_q;
    wire asleep = (pwr_state == `SQB_PWR_PRE_PD) || (pwr_state == `SQB_PWR_ACT_PD) ||
                  (pwr_state == `SQB_PWR_SELF_REF);
    // Clock counts as active only while enable stays high, buffers off asleep
    wire clk_act = clk_en & ~asleep;

    // Command qualification: chip select high masks all commands
    wire dec_en   = clk_act & ~cs_n;
    wire is_act   = dec_en && (cmd == `SQB_CMD_ACTIVE);
    wire is_rd    = dec_en && (cmd == `SQB_CMD_READ);
    wire is_wr    = dec_en && (cmd == `SQB_CMD_WRITE);
    wire is_bst   = dec_en && (cmd == `SQB_CMD_BST);
    wire is_pre   = dec_en && (cmd == `SQB_CMD_PRECHARGE);
    // Refresh with enable already low: clk_act is off then, so decode it apart
    wire is_sref  = !asleep && (cmd == `SQB_CMD_REFRESH) && !clk_en;
    wire ap_bit   = mux_address[`SQB_AP_BIT];

    // Burst state
    reg             rd_q, wr_q;
    reg [1:0]       bbank_q;
    reg [COL_W-1:0] start_q;
    reg [COL_W:0]   idx_q;
    reg [COL_W:0]   len_q;
    reg             ilv_q;
    wire            running = rd_q | wr_q;
    wire            last    = running && !len_q[COL_W] && (idx_q + 1'b1 == len_q);
    wire [COL_W-1:0] cur_col = next_col(start_q, idx_q, len_q, ilv_q);
    wire            start   = is_rd | is_wr;
    wire [COL_W-1:0] new_col = mux_address[COL_W-1:0];

    // Per-bank row tracking, bursts in one bank overlap precharge in another
    wire [3:0]        b_open;
    wire [ADDR_W-1:0] b_row [0:3];
    genvar g;
    generate
        for (g = 0; g < `SQB_BANKS; g = g + 1)
        begin : g_bank
            sqb_bank #(
                .ROW_W (ADDR_W)
            ) u_bank (
                .clk          (clk),
                .sys_rst      (sys_rst),
                .clk_act      (clk_act),
                .do_activate  (is_act && bank_select == g),
                .do_precharge (is_pre && (ap_bit || bank_select == g)),
                .arm_auto_pre (start && ap_bit && bank_select == g),
                .burst_done   (bbank_q == g && (last || is_bst || (start &&
                               running))),
                .row_in       (mux_address),
                .open_q       (b_open[g]),
                .row_q        (b_row[g])
            );
        end
    endgenerate

    // Burst counter advances once per active edge; restart on any new column
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            rd_q    <= 1'b0;
            wr_q    <= 1'b0;
            bbank_q <= 2'h0;
            start_q <= {COL_W{1'b0}};
            idx_q   <= {(COL_W+1){1'b0}};
            len_q   <= {(COL_W+1){1'b0}};
            ilv_q   <= 1'b0;
        end
        else if (clk_act) // suspend freezes the counter
        begin
            if (start)
            begin
                rd_q    <= is_rd && (burst_length != `SQB_BL_1);
                wr_q    <= is_wr && (burst_length != `SQB_BL_1);
                bbank_q <= bank_select;
                start_q <= new_col;
                idx_q   <= {{COL_W{1'b0}}, 1'b1}; // Beat zero goes with the command
                len_q   <= bl_len(burst_length);
                ilv_q   <= burst_interleave;
            end
            else if (is_bst || last || (is_pre && (ap_bit || bank_select == bbank_q)))
            begin
                rd_q <= 1'b0;
                wr_q <= 1'b0;
            end
            else if (running)
                idx_q <= idx_q + 1'b1; // continues under chip select high
        end
    end

    // Write path: mask lanes block data, first beat comes with the command
    wire             wr_now  = clk_act && (is_wr || (wr_q && !is_bst && !start));
    wire [LANES-1:0] dqm_now = (LANES > 1) ?
                               {{(LANES-1){data_mask_high_byte}}, data_mask_low_byte} :
                               data_mask_high_byte;
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            wr_stb     <= 1'b0;
            wr_bank    <= 2'h0;
            wr_row     <= {ADDR_W{1'b0}};
            wr_col     <= {COL_W{1'b0}};
            wr_data    <= {DQ_W{1'b0}};
            wr_byte_en <= {LANES{1'b0}};
        end
        else
        begin
            wr_stb     <= wr_now && (is_wr ? b_open[bank_select] : b_open[bbank_q]);
            wr_bank    <= is_wr ? bank_select : bbank_q;
            wr_row     <= is_wr ? b_row[bank_select] : b_row[bbank_q];
            wr_col     <= is_wr ? new_col : cur_col;
            wr_data    <= dq_in;
            wr_byte_en <= ~dqm_now;
        end
    end

    // Read pipe: data after CAS latency, mask tristates two clocks on
    reg [CAS_LAT-1:0]           rd_pipe_q;
    reg [LANES*`SQB_DQM_RD_LAT-1:0] dqm_pipe_q;
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            rd_pipe_q    <= {CAS_LAT{1'b0}};
            dqm_pipe_q   <= {(LANES*`SQB_DQM_RD_LAT){1'b0}};
            dq_out       <= {DQ_W{1'b0}};
            dq_oe_n      <= {LANES{1'b1}};
            rd_data_last <= {DQ_W{1'b0}};
        end
        else if (clk_act)
        begin
            rd_pipe_q  <= {rd_pipe_q[CAS_LAT-2:0], is_rd | (rd_q & ~is_bst & ~start)};
            dqm_pipe_q <= {dqm_pipe_q[LANES*(`SQB_DQM_RD_LAT-1)-1:0], dqm_now};
            dq_out     <= array_rd_data;
            rd_data_last <= array_rd_data;
            dq_oe_n    <= rd_pipe_q[CAS_LAT-1] ?
                          dqm_pipe_q[LANES*`SQB_DQM_RD_LAT-1 -: LANES] : {LANES{1'b1}};
        end
    end

    // Power states picked from bank and burst state when enable falls
    always @(posedge clk)
    begin
        if (sys_rst)
            pwr_state <= `SQB_PWR_RUN;
        else
        begin
            case (pwr_state)
                `SQB_PWR_RUN, `SQB_PWR_SUSPEND:
                begin
                    if (cke_s2_q && cke_s3_q)
                        pwr_state <= `SQB_PWR_RUN;
                    else if (!cke_s2_q && !cke_s3_q)
                    begin
                        if (running)
                            pwr_state <= `SQB_PWR_SUSPEND;
                        else if (|b_open)
                            pwr_state <= `SQB_PWR_ACT_PD;
                        else if (is_sref || sref_q)
                            pwr_state <= `SQB_PWR_SELF_REF;
                        else
                            pwr_state <= `SQB_PWR_PRE_PD;
                    end
                end
                `SQB_PWR_PRE_PD, `SQB_PWR_ACT_PD, `SQB_PWR_SELF_REF:
                    if (cke_hi_agree)
                        pwr_state <= `SQB_PWR_RUN;
                default: pwr_state <= `SQB_PWR_RUN;
            endcase
        end
    end

    // Status mirrors
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            bank_open  <= 4'h0;
            burst_busy <= 1'b0;
        end
        else
        begin
            bank_open  <= b_open;
            burst_busy <= running;
        end
    end
endmodule

// ---- tb/sqb_core_monitor.sv ----
// Checker on the ports of the quad-bank DRAM access core.
// Assumes one clock domain and the default 16-bit data width.
`timescale 1ns/1ns
`include "sqb_consts.vh"
module sqb_core_monitor (
    input wire        clk,
    input wire        sys_rst,
    input wire        clk_en,
    input wire        cs_n,
    input wire        ras_n,
    input wire        cas_n,
    input wire        we_n,
    input wire [1:0]  bank_select,
    input wire [12:0] mux_address,
    input wire        data_mask_low_byte,
    input wire        data_mask_high_byte,
    input wire [15:0] dq_in,
    input wire [1:0]  dq_oe_n,
    input wire        wr_stb,
    input wire [1:0]  wr_bank,
    input wire [8:0]  wr_col,
    input wire [15:0] wr_data,
    input wire [1:0]  wr_byte_en,
    input wire [2:0]  pwr_state,
    input wire [3:0]  bank_open,
    input wire        burst_busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Command as the core takes it: only with the clock live
    wire [3:0] cmd  = {cs_n, ras_n, cas_n, we_n};
    wire       take = clk_en && (pwr_state == `SQB_PWR_RUN);

    act_opens_a: assert property (take && cmd == `SQB_CMD_ACTIVE
        |-> ##2 bank_open[$past(bank_select, 2)])
        else $error("bank not open after activate");
    cs_masks_a: assert property (cs_n && !burst_busy |=> ##1 $stable(bank_open))
        else $error("deselected command changed bank state");
    pre_all_a: assert property (take && cmd == `SQB_CMD_PRECHARGE && mux_address[10]
        |-> ##2 bank_open == 4'h0)
        else $error("precharge all left a bank open");
    pre_one_a: assert property (take && cmd == `SQB_CMD_PRECHARGE && !mux_address[10]
        |-> ##2 !bank_open[$past(bank_select, 2)])
        else $error("single bank precharge missed");
    wr_start_a: assert property (take && cmd == `SQB_CMD_WRITE && bank_open[bank_select]
        |=> wr_stb && wr_col == $past(mux_address[8:0]) && wr_bank == $past(bank_select))
        else $error("write start column or bank wrong");
    wr_lane_a: assert property (wr_stb |-> wr_byte_en == ~$past({data_mask_high_byte, data_mask_low_byte})
        && (!wr_byte_en[0] || wr_data[7:0] == $past(dq_in[7:0])))
        else $error("write lane enable or data wrong");
    rd_mask_a: assert property ((dq_oe_n[0] || !$past(data_mask_low_byte, 3))
        && (dq_oe_n[1] || !$past(data_mask_high_byte, 3)))
        else $error("masked read lane driven");
    pd_idle_a: assert property (pwr_state == `SQB_PWR_PRE_PD |-> bank_open == 4'h0)
        else $error("precharge power-down with open row");
    pd_act_a: assert property (pwr_state == `SQB_PWR_ACT_PD |-> bank_open != 4'h0)
        else $error("active power-down with no open row");
    ck_off_a: assert property (!clk_en [*5] |-> pwr_state != `SQB_PWR_RUN)
        else $error("clock enable low but still running");
endmodule

bind sqb_core sqb_core_monitor mon_u (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select),
    .mux_address(mux_address), .data_mask_low_byte(data_mask_low_byte),
    .data_mask_high_byte(data_mask_high_byte), .dq_in(dq_in), .dq_oe_n(dq_oe_n),
    .wr_stb(wr_stb), .wr_bank(wr_bank), .wr_col(wr_col), .wr_data(wr_data),
    .wr_byte_en(wr_byte_en), .pwr_state(pwr_state), .bank_open(bank_open),
    .burst_busy(burst_busy));

// ---- tb/sqb_array_model.sv ----
// Stand-in for the storage array behind the core.
// Assumes write beats arrive as one-cycle strobes on clk.
`timescale 1ns/1ns
module sqb_array_model (
    input  wire        clk,
    input  wire        wr_stb,
    input  wire [1:0]  wr_byte_en,
    input  wire [15:0] wr_data,
    output wire [15:0] array_rd_data
);
    reg [15:0] word_q = 16'h0000;
    reg [15:0] spin_q = 16'h0000;
    // Masked lanes keep old bytes; spin moves the return each cycle
    // since no read address reaches this model
    always @(posedge clk)
    begin
        spin_q <= spin_q + 16'h0001;
        if (wr_stb && wr_byte_en[0])
            word_q[7:0] <= wr_data[7:0];
        if (wr_stb && wr_byte_en[1])
            word_q[15:8] <= wr_data[15:8];
    end
    assign array_rd_data = word_q ^ spin_q;
endmodule

// ---- tb/test_sqb_core.sv ----
// Self-checking bench for the DRAM core: bursts, masks, banks, power states.
// Assumes the core at default parameters with the array model beside it.
`timescale 1ns/1ns
`include "sqb_consts.vh"
module test_sqb_core;
    reg         clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg         clk_en = 1'b1;
    reg  [3:0]  cmd = `SQB_CMD_NOP;
    reg  [1:0]  ba = 2'h0;
    reg  [12:0] addr = 13'h0000;
    reg  [1:0]  dqm = 2'h0;
    reg  [2:0]  bl = `SQB_BL_4;
    reg  [15:0] din = 16'h0000;
    wire [15:0] dq_out, wr_data, rd_last, arr;
    wire [1:0]  dq_oe_n, wr_bank, wr_byte_en;
    wire        wr_stb, burst_busy;
    wire [12:0] wr_row;
    wire [8:0]  wr_col;
    wire [2:0]  pwr_state;
    wire [3:0]  bank_open;
    reg  [41:0] wlog [0:15];
    integer     bad_count = 0;
    integer     samples_checked = 0;
    integer     n_log = 0;
    integer     i, k, t;
    localparam [12:0] ROW0 = 13'h1abc;
    localparam [12:0] ROW1 = 13'h0421;

    sqb_core dut_u (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .cs_n(cmd[3]),
        .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]), .bank_select(ba), .mux_address(addr),
        .data_mask_low_byte(dqm[0]), .data_mask_high_byte(dqm[1]), .burst_length(bl),
        .burst_interleave(1'b0), .dq_in(din), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .wr_stb(wr_stb), .wr_bank(wr_bank), .wr_row(wr_row), .wr_col(wr_col),
        .wr_data(wr_data), .wr_byte_en(wr_byte_en), .rd_data_last(rd_last),
        .pwr_state(pwr_state), .bank_open(bank_open), .burst_busy(burst_busy),
        .array_rd_data(arr));
    sqb_array_model arr_u (.clk(clk), .wr_stb(wr_stb), .wr_byte_en(wr_byte_en),
        .wr_data(wr_data), .array_rd_data(arr));

    // 10 MHz clock
    always #50 clk = ~clk;

    // Record each write beat; a full log stops growing rather than wrapping
    always @(posedge clk)
    begin
        if (wr_stb === 1'b1 && n_log < 16)
        begin
            wlog[n_log] <= {wr_bank, wr_row, wr_col, wr_byte_en, wr_data};
            n_log <= n_log + 1;
        end
    end

    task chk(input [41:0] seen, input [41:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask

    task results;
    begin
        if (bad_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask

    // One command cycle, launched just after the edge
    task step(input [3:0] c, input [1:0] b, input [12:0] a, input [15:0] d, input [1:0] m);
    begin
        @(posedge clk);
        cmd <= c;
        ba <= b;
        addr <= a;
        din <= d;
        dqm <= m;
    end
    endtask

    task idle(input integer n);
    begin
        repeat (n) step(`SQB_CMD_NOP, 2'h0, 13'h0000, 16'h0000, 2'h0);
    end
    endtask

    // Write burst with the high byte masked on beat one; fc fills later cycles
    task wburst(input [1:0] b, input [8:0] col, input integer n, input ap, input [3:0] fc);
    begin
        n_log = 0;
        for (i = 0; i < n; i = i + 1)
            step((i == 0) ? `SQB_CMD_WRITE : fc, b, {2'b00, ap, 1'b0, col},
                16'ha500 + i[15:0], (i == 1) ? 2'b10 : 2'b00);
    end
    endtask

    // Expected beats wrap inside a block of w columns
    task wcheck(input [1:0] b, input [12:0] r, input [8:0] col, input integer n, input integer w);
        reg [8:0] ec;
    begin
        chk(n_log, n);
        for (i = 0; i < n; i = i + 1)
        begin
            ec = (col & ~(w - 1)) | ((col + i) & (w - 1));
            chk(wlog[i], {b, r, ec, (i == 1) ? 2'b01 : 2'b11, 16'ha500 + i[15:0]});
        end
    end
    endtask

    // Move clock enable and wait a bounded time for the power state
    task pwr(input ce, input [2:0] exp);
    begin
        @(posedge clk);
        clk_en <= ce;
        for (t = 0; t < 8 && pwr_state !== exp; t = t + 1)
            @(posedge clk);
        #1;
        chk(pwr_state, exp);
    end
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        idle(1);
        #1;
        chk({dq_oe_n, pwr_state, bank_open, burst_busy}, {2'b11, 3'h0, 4'h0, 1'b0});
        step(`SQB_CMD_ACTIVE, 2'h0, ROW0, 16'h0000, 2'h0);
        step(4'hb, 2'h1, ROW1, 16'h0000, 2'h0);
        idle(2);
        #1;
        chk(bank_open, 4'h1);
        for (k = 0; k < 4; k = k + 1)
        begin
            bl <= k[2:0];
            wburst(2'h0, 9'h00d, 1 << k, 1'b0, `SQB_CMD_NOP);
            idle(3);
            wcheck(2'h0, ROW0, 9'h00d, 1 << k, 1 << k);
        end
        bl <= `SQB_BL_PAGE;
        wburst(2'h0, 9'h1fe, 3, 1'b0, `SQB_CMD_NOP);
        step(`SQB_CMD_BST, 2'h0, 13'h0000, 16'h0000, 2'h0);
        idle(3);
        wcheck(2'h0, ROW0, 9'h1fe, 3, 512);
        bl <= `SQB_BL_4;
        wburst(2'h0, 9'h002, 4, 1'b0, 4'hc);
        idle(3);
        wcheck(2'h0, ROW0, 9'h002, 4, 4);
        bl <= `SQB_BL_1;
        n_log = 0;
        for (k = 0; k < 3; k = k + 1)
            step(`SQB_CMD_WRITE, 2'h0, 13'h0002 + k * 5, 16'ha500, 2'h0);
        idle(3);
        chk({n_log[3:0], wlog[0][26:18], wlog[1][26:18], wlog[2][26:18]},
            {4'h3, 9'h002, 9'h007, 9'h00c});
        step(`SQB_CMD_ACTIVE, 2'h1, ROW1, 16'h0000, 2'h0);
        bl <= `SQB_BL_4;
        n_log = 0;
        for (k = 0; k < 4; k = k + 1)
            step((k == 0) ? `SQB_CMD_WRITE : ((k == 1) ? `SQB_CMD_PRECHARGE : `SQB_CMD_NOP),
                (k == 0) ? 2'h1 : 2'h0, (k == 0) ? 13'h0404 : 13'h0000, 16'ha500 + k[15:0],
                (k == 1) ? 2'b10 : 2'b00);
        #1;
        chk(bank_open, 4'h2);
        idle(3);
        #1;
        chk(bank_open, 4'h0);
        wcheck(2'h1, ROW1, 9'h004, 4, 4);
        step(`SQB_CMD_ACTIVE, 2'h2, ROW1, 16'h0000, 2'h0);
        bl <= `SQB_BL_2;
        step(`SQB_CMD_READ, 2'h2, 13'h0008, 16'h0000, 2'h0);
        step(`SQB_CMD_NOP, 2'h0, 13'h0000, 16'h0000, 2'b01);
        idle(1);
        @(posedge clk);
        #1;
        chk(dq_oe_n, 2'b00);
        @(posedge clk);
        #1;
        chk(dq_oe_n, 2'b01);
        idle(3);
        #1;
        chk(dq_oe_n, 2'b11);
        step(`SQB_CMD_PRECHARGE, 2'h0, 13'h0400, 16'h0000, 2'h0);
        idle(2);
        #1;
        chk(bank_open, 4'h0);
        pwr(1'b0, `SQB_PWR_PRE_PD);
        pwr(1'b1, `SQB_PWR_RUN);
        step(`SQB_CMD_ACTIVE, 2'h3, ROW0, 16'h0000, 2'h0);
        pwr(1'b0, `SQB_PWR_ACT_PD);
        pwr(1'b1, `SQB_PWR_RUN);
        step(`SQB_CMD_PRECHARGE, 2'h0, 13'h0400, 16'h0000, 2'h0);
        idle(1);
        step(`SQB_CMD_REFRESH, 2'h0, 13'h0000, 16'h0000, 2'h0);
        clk_en <= 1'b0;
        idle(1);
        pwr(1'b0, `SQB_PWR_SELF_REF);
        pwr(1'b1, `SQB_PWR_RUN);
        step(`SQB_CMD_ACTIVE, 2'h0, ROW0, 16'h0000, 2'h0);
        bl <= `SQB_BL_8;
        step(`SQB_CMD_WRITE, 2'h0, 13'h0000, 16'ha500, 2'h0);
        idle(1);
        pwr(1'b0, `SQB_PWR_SUSPEND);
        chk(burst_busy, 1'b1);
        pwr(1'b1, `SQB_PWR_RUN);
        for (t = 0; t < 20 && burst_busy !== 1'b0; t = t + 1)
            @(posedge clk);
        #1;
        chk(burst_busy, 1'b0);
        idle(2);
        results;
    end

    // Cut a hang short well past the expected run of under two hundred cycles
    initial
    begin
        #300000;
        bad_count = bad_count + 1;
        results;
    end
endmodule
